// ==== group_based_bit_allocator.sv ====
/*
  Group based bit allocator: one frame of 26 norms and a budget in,
  26 per-band bit counts out, with a start/done handshake.
  Assumes the norm stage holds i_frame stable in the start cycle and
  that the consumer samples o_alloc when o_done pulses.
*/
// Contract
// - only wideband, non-transient frames at the two middle rates are allocated
// - reference level is sum of norms 10..17 divided by 8
// - lowest four norms below the reference are raised to it
// - every band starts at zero bits; groups 0-15, 16-23, 24-25
// - weighting factors start at 2 and 3
// - group means and their sum are computed
// - differences of consecutive group means are formed
// - large differences: floor split, group 1 scaled 0.92, group 2 remainder
// - otherwise each group gets floor of budget times mean over sum
// - capping applies only when third mean exceeds 12
// - clip groups to 288, 256, 96 and save the excess
// - half of saved bits to group 0 or 1, remainder to 1 or 2
// - after capping the factors become 2 and 1.5
// - third group below 3 bits moves into group 1
// - thresholds 5, 6, 7; max band count is budget over threshold
// - norms re-ordered per group; step is one over band count
// - re-ordered norm scaled by factor minus position times step, truncated
// - max count at least 0.75 of bands: all bands counted, clamp negatives
// - counter from last band; drop the last band while below threshold
// - otherwise only the first max-count bands are counted
// - any counted band below threshold zeroes it and all after it
// - counter becomes the failing position and allocation repeats
`timescale 1ns/1ps
`include "alloc_consts.svh"
module group_based_bit_allocator
  import alloc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire frame_t i_frame,
  output logic o_busy,
  output logic o_done,
  output logic o_bypass,
  output alloc_vec_t o_alloc
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic int sum_range(input norm_vec_t n, input int lo, input int hi);
    int s;
    s = 0;
    for (int j = 0; j < `NBANDS; j++)
      if (j >= lo && j <= hi)
        s = s + int'(n[j]);
    return s;
  endfunction : sum_range

  function automatic int grp_start(input int b);
    return (b < `G1_START) ? 0 : ((b < `G2_START) ? `G1_START : `G2_START);
  endfunction : grp_start

  function automatic int grp_len(input int b);
    return (b < `G1_START) ? `G0_N : ((b < `G2_START) ? `G1_N : `G2_N);
  endfunction : grp_len

  // position in descending order; ties keep the lower band first
  function automatic logic [4:0] rank_of(input norm_vec_t n, input int b);
    int s;
    logic [4:0] r;
    s = grp_start(b);
    r = 5'h00;
    for (int j = 0; j < `NBANDS; j++)
      if (j >= s && j < s + grp_len(b) && (n[j] > n[b] || (n[j] == n[b] && j < b)))
        r = r + 5'h01;
    return r;
  endfunction : rank_of

  // n * (f - p/N) with f doubled: n * (2fN/2 - p) / N = n * (fx2*N - 2p) / 2N
  function automatic logic [15:0] adj_of(input norm_t n, input logic [4:0] p,
                                         input int fx2, input int nb);
    int t;
    t = int'(n) * (fx2 * nb - 2 * int'(p));
    if (t < 0)
      t = 0;
    return 16'(t / (2 * nb));
  endfunction : adj_of

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  state_t state_reg;
  norm_vec_t norm_reg;
  logic [`BUD_W-1:0] bud_reg;
  logic [2:0][`BUD_W-1:0] rg_reg;
  logic [3:0] f1x2_reg;
  logic [1:0] g_reg;
  logic [4:0] idx_reg;
  logic [4:0] cnt_reg;
  logic [4:0] q_reg;
  logic [15:0] sum_reg;
  logic fail_reg;
  logic case_a_reg;
  logic done_reg;
  logic busy_reg;
  logic bypass_reg;
  alloc_vec_t alloc_reg;

  // ------------------------------------------------------------
  // frame intake and low-band lift
  // ------------------------------------------------------------
  wire logic eligible_w = i_frame.wideband && !i_frame.transient &&
    (i_frame.rate == `RATE_24K4 || i_frame.rate == `RATE_32K);
  wire norm_t ref_in_w =
    `NORM_W'(sum_range(i_frame.norms, `REF_LO, `REF_HI) >> `REF_SHIFT);
  norm_vec_t lifted_w;
  genvar gb;
  generate
    for (gb = 0; gb < `NBANDS; gb++)
    begin : g_lift
      if (gb < `LIFT_BANDS)
      begin : g_lo
        assign lifted_w[gb] = (i_frame.norms[gb] < ref_in_w) ?
          ref_in_w : i_frame.norms[gb];
      end
      else
      begin : g_hi
        assign lifted_w[gb] = i_frame.norms[gb];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // budget split among groups
  // ------------------------------------------------------------
  logic [2:0][`BUD_W-1:0] rg_w;
  logic [3:0] f1x2_w;
  logic hi_w;
  logic capped_w;
  always_comb
  begin
    int m0, m1, m2, s, b, r0, r1, r2, sav;
    logic k0, k1;
    m0 = sum_range(norm_reg, 0, `G1_START - 1);
    m1 = 2 * sum_range(norm_reg, `G1_START, `G2_START - 1);
    m2 = 8 * sum_range(norm_reg, `G2_START, `NBANDS - 1);
    s = m0 + m1 + m2;
    b = int'(bud_reg);
    r0 = 0;
    r1 = 0;
    r2 = 0;
    sav = 0;
    k0 = 1'b0;
    k1 = 1'b0;
    f1x2_w = 4'(`F1X2_INIT);
    hi_w = (m0 - m1 >= `HI_D0) || (m1 - m2 >= `HI_D1);
    capped_w = 1'b0;
    if (s == 0)
    begin
      r0 = b;
      r1 = 0;
      r2 = 0;
    end
    else if (hi_w)
    begin
      r0 = b * m0 / s;
      r1 = (`P092_NUM * b * m1) / (`P092_DEN * s);
      r2 = b - r0 - r1;
    end
    else
    begin
      r0 = b * m0 / s;
      r1 = b * m1 / s;
      r2 = b * m2 / s;
      if (m2 > `M2_LIM)
      begin
        capped_w = 1'b1;
        if (r0 > `CAP0)
        begin
          sav = r0 - `CAP0;
          r0 = `CAP0;
        end
        if (r1 > `CAP1)
        begin
          sav = sav + r1 - `CAP1;
          r1 = `CAP1;
        end
        if (r2 > `CAP2)
        begin
          sav = sav + r2 - `CAP2;
          r2 = `CAP2;
        end
        k0 = (r0 == `CAP0);
        k1 = (r1 == `CAP1);
        if (sav > 0)
        begin
          if (!k0)
            r0 = r0 + sav / 2;
          else
            r1 = r1 + sav / 2;
          if (!k0 && !k1)
            r1 = b - r0 - r2;
          else
            r2 = b - r0 - r1;
        end
        f1x2_w = 4'(`F1X2_CAP);
      end
    end
    if (r2 < `SMALL_G2)
    begin
      r1 = r1 + r2;
      r2 = 0;
    end
    rg_w[0] = `BUD_W'(r0);
    rg_w[1] = `BUD_W'(r1);
    rg_w[2] = `BUD_W'(r2);
  end

  // ------------------------------------------------------------
  // per-band ordering and adjusted norms
  // ------------------------------------------------------------
  logic [`NBANDS-1:0][4:0] pos_w;
  logic [`NBANDS-1:0][15:0] adj_w;
  generate
    for (gb = 0; gb < `NBANDS; gb++)
    begin : g_band
      assign pos_w[gb] = rank_of(norm_reg, gb);
      assign adj_w[gb] = adj_of(norm_reg[gb], pos_w[gb],
        (gb < `G1_START) ? `F0X2 : int'(f1x2_reg), grp_len(gb));
    end
  endgenerate

  // ------------------------------------------------------------
  // current group selection
  // ------------------------------------------------------------
  wire logic [4:0] gs_w = (g_reg == 2'h0) ? 5'h00 :
    ((g_reg == 2'h1) ? 5'(`G1_START) : 5'(`G2_START));
  wire logic [4:0] gn_w = (g_reg == 2'h0) ? 5'(`G0_N) :
    ((g_reg == 2'h1) ? 5'(`G1_N) : 5'(`G2_N));
  wire logic [3:0] thr_w = (g_reg == 2'h0) ? 4'(`THR0) :
    ((g_reg == 2'h1) ? 4'(`THR1) : 4'(`THR2));
  wire logic [`BUD_W-1:0] rg_cur_w = rg_reg[g_reg];
  wire logic [`BUD_W-1:0] nmax_w = rg_cur_w / `BUD_W'(thr_w);
  // nmax >= 0.75 N, kept in integers as 4*nmax >= 3*N
  wire logic case_a_w = ({2'h0, nmax_w} << 2) >= (13'(gn_w) * 13'h3);
  wire logic [4:0] last_w = gs_w + gn_w - 5'h01;
  wire logic [4:0] pos_cur_w = pos_w[idx_reg];
  wire logic pos_in_w = case_a_reg ? (pos_cur_w <= cnt_reg) : (pos_cur_w < cnt_reg);
  wire logic [15:0] adj_cur_w = pos_in_w ? adj_w[idx_reg] : 16'h0000;
  // an empty norm sum gives zero bits, which then prunes the band
  wire logic [26:0] val_w = (sum_reg == 16'h0000) ? 27'h0000000 :
    (27'(rg_cur_w) * 27'(adj_cur_w)) / 27'(sum_reg);
  wire logic below_w = pos_in_w && (val_w < 27'(thr_w)) &&
    (!case_a_reg || pos_cur_w == cnt_reg);
  wire logic retry_w = fail_reg && !(case_a_reg && cnt_reg == 5'h00);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_reg <= ST_IDLE;
      norm_reg <= '0;
      bud_reg <= '0;
      rg_reg <= '0;
      f1x2_reg <= 4'(`F1X2_INIT);
      g_reg <= 2'h0;
      idx_reg <= 5'h00;
      cnt_reg <= 5'h00;
      q_reg <= 5'h00;
      sum_reg <= 16'h0000;
      fail_reg <= 1'b0;
      case_a_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      bypass_reg <= 1'b0;
      alloc_reg <= '0;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
          if (i_start)
          begin
            alloc_reg <= '0;
            bypass_reg <= !eligible_w;
            bud_reg <= i_frame.budget;
            norm_reg <= lifted_w;
            busy_reg <= eligible_w;
            done_reg <= !eligible_w;
            if (eligible_w)
              state_reg <= ST_SPLIT;
          end
        ST_SPLIT:
        begin
          rg_reg <= rg_w;
          f1x2_reg <= f1x2_w;
          g_reg <= 2'h0;
          state_reg <= ST_GINIT;
        end
        ST_GINIT:
        begin
          case_a_reg <= case_a_w;
          cnt_reg <= case_a_w ? gn_w - 5'h01 : 5'(nmax_w);
          idx_reg <= gs_w;
          sum_reg <= 16'h0000;
          state_reg <= ST_SUM;
        end
        ST_SUM:
        begin
          sum_reg <= sum_reg + adj_cur_w;
          idx_reg <= (idx_reg == last_w) ? gs_w : idx_reg + 5'h01;
          fail_reg <= 1'b0;
          q_reg <= cnt_reg;
          if (idx_reg == last_w)
            state_reg <= ST_ALLOC;
        end
        ST_ALLOC:
        begin
          alloc_reg[idx_reg] <= `BUD_W'(val_w);
          if (below_w)
          begin
            fail_reg <= 1'b1;
            if (pos_cur_w < q_reg)
              q_reg <= pos_cur_w;
          end
          idx_reg <= idx_reg + 5'h01;
          if (idx_reg == last_w)
            state_reg <= ST_DECIDE;
        end
        ST_DECIDE:
          if (retry_w)
          begin
            cnt_reg <= case_a_reg ? cnt_reg - 5'h01 : q_reg;
            idx_reg <= gs_w;
            sum_reg <= 16'h0000;
            state_reg <= ST_SUM;
          end
          else if (g_reg == 2'h2)
          begin
            done_reg <= 1'b1;
            busy_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else
          begin
            g_reg <= g_reg + 2'h1;
            state_reg <= ST_GINIT;
          end
      endcase
    end
  end

  assign o_busy = busy_reg;
  assign o_done = done_reg;
  assign o_bypass = bypass_reg;
  assign o_alloc = alloc_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire norm_t ref_now_w = `NORM_W'(sum_range(norm_reg, `REF_LO, `REF_HI) >> `REF_SHIFT);

  property p_bypass;
    state_reg == ST_IDLE && i_start && !eligible_w |=> o_done && o_bypass && o_alloc == '0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("ineligible frame not bypassed");
  property p_lift;
    state_reg == ST_SPLIT |-> norm_reg[0] >= ref_now_w && norm_reg[1] >= ref_now_w &&
      norm_reg[2] >= ref_now_w && norm_reg[3] >= ref_now_w;
  endproperty
  a_lift: assert property (p_lift) else $error("low band below reference");
  property p_factor;
    state_reg == ST_SPLIT ##1 state_reg == ST_GINIT |->
      f1x2_reg == (capped_w ? 4'(`F1X2_CAP) : 4'(`F1X2_INIT));
  endproperty
  a_factor: assert property (p_factor) else $error("weighting factor wrong");
  property p_small;
    state_reg == ST_GINIT |-> rg_reg[2] == '0 || rg_reg[2] >= `BUD_W'(`SMALL_G2);
  endproperty
  a_small: assert property (p_small) else $error("third group under 3 bits");
  property p_cap;
    state_reg == ST_SPLIT && capped_w && rg_w[0] != `BUD_W'(`CAP0) |->
      // group 0 below its cap gains at most half the saved bits, so stays within CAP0 plus half the budget
      12'(rg_w[0]) <= 12'(`CAP0) + 12'(bud_reg >> 1);
  endproperty
  a_cap: assert property (p_cap) else $error("group 0 exceeds budget");
  property p_out_zero;
    state_reg == ST_ALLOC && !pos_in_w |=> alloc_reg[$past(idx_reg)] == '0;
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("uncounted band got bits");
  property p_cnt_dec;
    state_reg == ST_DECIDE && retry_w && case_a_reg |=>
      cnt_reg == $past(cnt_reg) - 5'h01 ##1 state_reg == ST_SUM;
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("counter not decremented");
  property p_cnt_q;
    state_reg == ST_DECIDE && retry_w && !case_a_reg |=> cnt_reg < $past(cnt_reg);
  endproperty
  a_cnt_q: assert property (p_cnt_q) else $error("counter not cut to failing band");
  property p_done;
    // a start taken in the done cycle may legally raise done again
    o_done |-> !o_busy ##1 (!o_done || $past(i_start));
  endproperty
  a_done: assert property (p_done) else $error("done not a single pulse");

  c_hi: cover property (state_reg == ST_SPLIT && hi_w);
  c_capped: cover property (state_reg == ST_SPLIT && capped_w);
  c_retry_a: cover property (state_reg == ST_DECIDE && retry_w && case_a_reg);
  c_retry_b: cover property (state_reg == ST_DECIDE && retry_w && !case_a_reg);
endmodule : group_based_bit_allocator

// ==== alloc_consts.svh ====
/*
  Constants of the group based bit allocator: band layout, limits,
  thresholds and fixed-point scalings. Assumes nothing beyond inclusion.
*/
`ifndef ALLOC_CONSTS_SVH
`define ALLOC_CONSTS_SVH
`define NBANDS 26
`define NORM_W 8
`define BUD_W 11
`define REF_LO 10
`define REF_HI 17
`define REF_SHIFT 3
`define LIFT_BANDS 4
`define G1_START 16
`define G2_START 24
`define G0_N 16
`define G1_N 8
`define G2_N 2
`define CAP0 288
`define CAP1 256
`define CAP2 96
// means are held in sixteenths: 6 -> 96, 3.75 -> 60, 12 -> 192
`define HI_D0 96
`define HI_D1 60
`define M2_LIM 192
`define P092_NUM 92
`define P092_DEN 100
// factors are held doubled: 2 -> 4, 3 -> 6, 1.5 -> 3
`define F0X2 4
`define F1X2_INIT 6
`define F1X2_CAP 3
`define SMALL_G2 3
`define THR0 5
`define THR1 6
`define THR2 7
`define RATE_24K4 2'h1
`define RATE_32K 2'h2
`endif

// ==== alloc_pkg.sv ====
/*
  Types of the group based bit allocator.
  Assumes alloc_consts.svh is on the include path.
*/
`include "alloc_consts.svh"
package alloc_pkg;
  typedef logic [`NORM_W-1:0] norm_t;
  typedef norm_t [`NBANDS-1:0] norm_vec_t;
  typedef logic [`NBANDS-1:0][`BUD_W-1:0] alloc_vec_t;
  typedef struct packed {
    logic wideband;
    logic transient;
    logic [1:0] rate;
    logic [`BUD_W-1:0] budget;
    norm_vec_t norms;
  } frame_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SPLIT = 6'h02,
    ST_GINIT = 6'h04,
    ST_SUM = 6'h08,
    ST_ALLOC = 6'h10,
    ST_DECIDE = 6'h20
  } state_t;
endpackage : alloc_pkg

// ==== frame_source.sv ====
/*
  Partner model: the norm stage that offers one frame per start pulse,
  and the fine-structure stage that takes the allocation when done stands.
  Assumes alloc_pkg is compiled first and the clock is shared with the allocator.
*/
`timescale 1ns/1ps
module frame_source
  import alloc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_done,
  input wire logic i_bypass,
  input wire alloc_vec_t i_alloc,
  output logic o_start,
  output frame_t o_frame
);
  int dones = 0;
  alloc_vec_t got_alloc;
  logic got_bypass;

  initial
  begin
    o_start = 1'b0;
    o_frame = '0;
  end

  // -----------------------------------------------
  // request side
  // -----------------------------------------------
  // the frame is qualified only in the start cycle; afterwards the bus shows
  // the inverse so that a late sample cannot pass for the real frame
  task automatic offer(input frame_t f);
    @(negedge i_ref_clk);
    o_start = 1'b1;
    o_frame = f;
    @(negedge i_ref_clk);
    o_start = 1'b0;
    o_frame = ~f;
  endtask : offer

  // -----------------------------------------------
  // consumer side
  // -----------------------------------------------
  always @(posedge i_ref_clk)
  begin
    if (i_done === 1'b1)
    begin
      got_alloc <= i_alloc;
      got_bypass <= i_bypass;
      dones <= dones + 1;
    end
  end
endmodule : frame_source

// ==== testbench.sv ====
/*
  Self-checking bench of the group based bit allocator: integer reference
  model, directed and random frames, refusals and resets.
  Assumes alloc_pkg, alloc_consts.svh and frame_source are available.
*/
`timescale 1ns/1ps
`include "alloc_consts.svh"
module testbench
  import alloc_pkg::*;
;
  logic i_ref_clk;
  logic i_rst;
  logic start;
  logic o_busy;
  logic o_done;
  logic o_bypass;
  frame_t frame;
  frame_t f;
  alloc_vec_t o_alloc;
  alloc_vec_t exp_alloc;
  logic exp_byp;
  logic [31:0] seed;
  int mismatches;
  int checks;
  int cycles;

  group_based_bit_allocator uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_start(start),
    .i_frame(frame), .o_busy(o_busy), .o_done(o_done), .o_bypass(o_bypass), .o_alloc(o_alloc));
  frame_source p (.i_ref_clk(i_ref_clk), .i_done(o_done), .i_bypass(o_bypass),
    .i_alloc(o_alloc), .o_start(start), .o_frame(frame));

  // -----------------------------------------------
  // reporting
  // -----------------------------------------------
  task automatic check(input alloc_vec_t seen, input alloc_vec_t want, input string what);
    checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // -----------------------------------------------
  // reference model
  // -----------------------------------------------
  task automatic model(input frame_t fr);
    int n[26], m[3], g[3], fx[3], nb[3], th[3], cap[3], pos[26], nr[16], adj[16], bits[16];
    int bg, rf, ms, sv, lo, nmax, cnt, lim, sum, q;
    bit c0, c1, a, again;
    exp_alloc = '0;
    exp_byp = !(fr.wideband && !fr.transient && (fr.rate == `RATE_24K4 || fr.rate == `RATE_32K));
    if (exp_byp)
      return;
    nb = '{`G0_N, `G1_N, `G2_N};
    th = '{`THR0, `THR1, `THR2};
    cap = '{`CAP0, `CAP1, `CAP2};
    fx = '{`F0X2, `F1X2_INIT, `F1X2_INIT};
    bg = fr.budget;
    rf = 0;
    for (int b = 0; b < 26; b++) n[b] = fr.norms[b];
    for (int b = `REF_LO; b <= `REF_HI; b++) rf += n[b];
    rf = rf / 8;
    for (int b = 0; b < `LIFT_BANDS; b++) if (n[b] < rf) n[b] = rf;
    for (int b = 0; b < 26; b++) m[b < 16 ? 0 : (b < 24 ? 1 : 2)] += 16 * n[b];
    for (int k = 0; k < 3; k++) m[k] = m[k] / nb[k];
    ms = m[0] + m[1] + m[2];
    if (ms == 0)
      g = '{bg, 0, 0};
    else if (m[0] - m[1] >= `HI_D0 || m[1] - m[2] >= `HI_D1)
    begin
      g[0] = bg * m[0] / ms;
      g[1] = `P092_NUM * bg * m[1] / (`P092_DEN * ms);
      g[2] = bg - g[0] - g[1];
    end
    else
    begin
      for (int k = 0; k < 3; k++) g[k] = bg * m[k] / ms;
      if (m[2] > `M2_LIM)
      begin
        sv = 0;
        for (int k = 0; k < 3; k++)
          if (g[k] > cap[k])
          begin
            sv += g[k] - cap[k];
            g[k] = cap[k];
          end
        c0 = (g[0] == `CAP0);
        c1 = (g[1] == `CAP1);
        if (sv > 0)
        begin
          g[c0 ? 1 : 0] += sv / 2;
          if (!c0 && !c1)
            g[1] = bg - g[0] - g[2];
          else
            g[2] = bg - g[0] - g[1];
        end
        fx = '{`F0X2, `F1X2_CAP, `F1X2_CAP};
      end
    end
    if (g[2] < `SMALL_G2)
    begin
      g[1] += g[2];
      g[2] = 0;
    end
    for (int k = 0; k < 3; k++)
    begin
      lo = (k == 0) ? 0 : (k == 1 ? `G1_START : `G2_START);
      for (int b = lo; b < lo + nb[k]; b++)
      begin
        pos[b] = 0;
        for (int c = lo; c < lo + nb[k]; c++)
          if (n[c] > n[b] || (n[c] == n[b] && c < b)) pos[b]++;
        nr[pos[b]] = n[b];
      end
      for (int p = 0; p < nb[k]; p++)
      begin
        adj[p] = nr[p] * (fx[k] * nb[k] / 2 - p) / nb[k];
        if (adj[p] < 0) adj[p] = 0;
      end
      nmax = g[k] / th[k];
      a = (4 * nmax >= 3 * nb[k]);
      cnt = a ? nb[k] - 1 : nmax;
      again = 1;
      while (again)
      begin
        sum = 0;
        q = -1;
        lim = a ? cnt + 1 : cnt;
        for (int p = 0; p < lim; p++) sum += adj[p];
        for (int p = 0; p < 16; p++) bits[p] = (p < lim && sum > 0) ? g[k] * adj[p] / sum : 0;
        for (int p = lim - 1; p >= 0; p--) if (bits[p] < th[k]) q = p;
        again = a ? (cnt > 0 && bits[cnt] < th[k]) : (q >= 0);
        if (again) cnt = a ? cnt - 1 : q;
      end
      for (int b = lo; b < lo + nb[k]; b++) exp_alloc[b] = 11'(bits[pos[b]]);
    end
  endtask : model

  // -----------------------------------------------
  // stimulus
  // -----------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // one level per group plus per-band jitter, so the high-difference, capped and plain split branches turn up
  function automatic frame_t rand_frame();
    frame_t r;
    int lvl;
    lvl = 0;
    seed = lfsr(seed);
    r.wideband = 1'b1;
    r.transient = 1'b0;
    r.rate = seed[0] ? `RATE_24K4 : `RATE_32K;
    r.budget = 11'(100 + seed[20:10] % 1948);
    for (int b = 0; b < 26; b++)
    begin
      seed = lfsr(seed);
      if (b == 0 || b == 16 || b == 24) lvl = seed[13:8];
      r.norms[b] = 8'(lvl + seed[3:0]);
    end
    return r;
  endfunction : rand_frame

  task automatic do_reset;
    @(negedge i_ref_clk);
    i_rst = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    i_rst = 1'b0;
    check(286'({o_busy, o_done, o_bypass}), '0, "flags after reset");
    check(o_alloc, '0, "alloc after reset");
  endtask : do_reset

  task automatic run(input frame_t fr, input bit poke);
    int d0;
    model(fr);
    d0 = p.dones;
    p.offer(fr);
    check(286'(o_done), 286'(exp_byp), "done latency");
    check(286'(o_busy), 286'(!exp_byp), "busy");
    if (!exp_byp) check(o_alloc, '0, "cleared at start");
    if (poke) p.offer(~fr);
    for (int k = 0; k < 900 && p.dones == d0; k++) @(negedge i_ref_clk);
    check(p.got_alloc, exp_alloc, "allocation");
    check(286'(p.got_bypass), 286'(exp_byp), "bypass");
    check(o_alloc, exp_alloc, "held after done");
    check(286'(p.dones - d0), 286'(1), "one done per frame");
    check(286'(o_busy), '0, "idle after done");
  endtask : run

  initial
  begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // a hang counts as a mismatch and ends in the same report
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial
  begin
    i_rst = 1'b1;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    seed = 32'hDCE8;
    do_reset();
    for (int k = 0; k < 4; k++)
    begin
      f = rand_frame();
      case (k)
        0: f.wideband = 1'b0;
        1: f.transient = 1'b1;
        default: f.rate = (k == 2) ? 2'h0 : 2'h3;
      endcase
      run(f, 1'b0);
    end
    do_reset();
    f = rand_frame();
    f.norms = '0;
    run(f, 1'b0);
    f.budget = 11'h7FF;
    for (int b = 0; b < 26; b++) f.norms[b] = 8'h28;
    run(f, 1'b1);
    for (int b = 0; b < 26; b++) f.norms[b] = (b < 16) ? 8'h3C : 8'h04;
    run(f, 1'b0);
    for (int k = 0; k < 40; k++) run(rand_frame(), 1'b0);
    p.offer(rand_frame());
    repeat (30) @(negedge i_ref_clk);
    do_reset();
    run(rand_frame(), 1'b0);
    tally_and_finish();
  end
endmodule : testbench
